// file: logic/eeacc_params.svh
// Constants of the serial memory access engine: sizes, codes and timing
`ifndef EEACC_PARAMS_SVH
`define EEACC_PARAMS_SVH
`define EEACC_CLK_NS     4
`define EEACC_TWR_NS     5000000
`define EEACC_TWR_CYC    (`EEACC_TWR_NS / `EEACC_CLK_NS)
`define EEACC_PREFIX     4'ha
`define EEACC_PAGE_BYTES 16
`define EEACC_WRAP_BITS  3
`define EEACC_ADDR_BITS  11
`define EEACC_BYTE_BITS  8
`define EEACC_BUF_DEPTH  2
`endif

// file: logic/eeacc_pkg.sv
// Types shared by the serial memory access engine
`default_nettype none
package eeacc_pkg;
`include "eeacc_params.svh"
   // Protocol states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE    = 9'h001,
      ST_DEV     = 9'h002,
      ST_DEVACK  = 9'h004,
      ST_WADR    = 9'h008,
      ST_WADRACK = 9'h010,
      ST_WDATA   = 9'h020,
      ST_WDATACK = 9'h040,
      ST_RDATA   = 9'h080,
      ST_RACK    = 9'h100
   } eeacc_state_t;
   // Line events seen at the pins
   typedef enum logic [1:0] {
      EV_START = 2'h0,
      EV_STOP  = 2'h1,
      EV_RISE  = 2'h2,
      EV_FALL  = 2'h3
   } eeacc_evk_t;
   typedef struct packed {
      eeacc_evk_t kind;   // Event kind
      logic       sda;    // Data level at a clock rise
   } eeacc_ev_t;
   // One byte bound for the array
   typedef struct packed {
      logic [`EEACC_ADDR_BITS-1:0] addr;
      logic [`EEACC_BYTE_BITS-1:0] data;
   } eeacc_wr_t;
   // Pin sampler state, link domain
   typedef struct packed {
      logic [2:0] scl_p;
      logic [2:0] sda_p;
      logic       scl_f;
      logic       sda_f;
      logic       ev_v;
      eeacc_ev_t  ev;
   } eeacc_link_t;
   // Event crossing, both halves
   typedef struct packed {
      logic      tgl;
      eeacc_ev_t ev;
   } eeacc_xsrc_t;
   typedef struct packed {
      logic [2:0] t;
      logic       v;
      eeacc_ev_t  ev;
   } eeacc_xdst_t;
   // Two-entry buffer
   typedef struct packed {
      eeacc_wr_t [`EEACC_BUF_DEPTH-1:0] slot;
      logic [1:0]                       n;
   } eeacc_buf_t;
   // Protocol engine, core domain
   typedef struct packed {
      eeacc_state_t                st;
      logic [3:0]                  cnt;
      logic [`EEACC_BYTE_BITS-1:0] shreg;
      logic [`EEACC_BYTE_BITS-1:0] tx;
      logic                        rw;
      logic [2:0]                  page;
      logic [`EEACC_ADDR_BITS-1:0] addr;
      logic                        mack;
      logic                        oe_n;
      logic                        pend;
      logic                        busy;
      logic [31:0]                 tmr;
      logic                        push;
      eeacc_wr_t                   wr;
      logic                        dgap;
   } eeacc_core_t;
endpackage
`default_nettype wire

// file: logic/eeacc_evsync.sv
// Event crossing from the link clock into the core clock
`timescale 1ns/1ns
`default_nettype none
module eeacc_evsync (
   input  wire logic                i_link_clk,
   input  wire logic                i_core_clk,
   input  wire logic                i_rstn,
   input  wire logic                i_src_v,
   input  wire eeacc_pkg::eeacc_ev_t i_src_ev,
   output logic                     o_dst_v,
   output eeacc_pkg::eeacc_ev_t     o_dst_ev
);
   import eeacc_pkg::*;
   eeacc_xsrc_t s, next_s;   // Toggle and held event
   eeacc_xdst_t d, next_d;   // Toggle synchroniser

   // Source: flip the toggle and hold the event until the next one
   always_comb begin
      next_s = s;
      if (i_src_v) begin
         next_s.tgl = ~s.tgl;
         next_s.ev  = i_src_ev;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Destination: three stages, the first read only by the second
   // Held event is stable long before the toggle lands, so it is safe to take
   always_comb begin
      next_d      = d;
      next_d.t    = {d.t[1:0], s.tgl};
      next_d.v    = d.t[1] ^ d.t[2];
      if (d.t[1] ^ d.t[2]) begin
         next_d.ev = s.ev;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         d <= '0;
      end else begin
         d <= next_d;
      end
   end

   assign o_dst_v  = d.v;
   assign o_dst_ev = d.ev;
endmodule
`default_nettype wire

// file: logic/eeacc_buf2.sv
// Two-entry buffer between the protocol engine and the array
`timescale 1ns/1ns
`default_nettype none
module eeacc_buf2 (
   input  wire logic                i_core_clk,
   input  wire logic                i_rstn,
   input  wire logic                i_in_v,
   input  wire eeacc_pkg::eeacc_wr_t i_in,
   output logic                     o_in_ready,
   output logic                     o_out_v,
   output eeacc_pkg::eeacc_wr_t     o_out,
   input  wire logic                i_out_ready
);
   import eeacc_pkg::*;
   eeacc_buf_t b, next_b;   // Slots and fill count
   logic       push;        // Accepted write
   logic       pop;         // Accepted read

   assign o_in_ready = (b.n != 2'h2);
   assign o_out_v    = (b.n != 2'h0);
   assign o_out      = b.slot[0];
   assign push       = i_in_v & o_in_ready;
   assign pop        = o_out_v & i_out_ready;

   // Head sits in slot 0; a pop shifts slot 1 down
   always_comb begin
      next_b = b;
      if (pop) begin
         next_b.slot[0] = b.slot[1];
      end
      if (push) begin
         if (b.n == 2'h0 || (b.n == 2'h1 && pop)) begin
            next_b.slot[0] = i_in;
         end else begin
            next_b.slot[1] = i_in;
         end
      end
      next_b.n = b.n + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         b <= '0;
      end else begin
         b <= next_b;
      end
   end
endmodule
`default_nettype wire

// file: logic/eeacc_top.sv
// Two-wire access engine of a small serial memory, device side
// Summary of operation
// - Last address bit: one reads, zero writes
// - Matching address is acknowledged, else back to idle
// - Byte write: word address, data, stop
// - Stop after write starts timed programming, no answers
// - Page writes of eight bytes are accepted
// - Page write: more bytes, each acknowledged, stop
// - Only low three address bits advance on write
// - Past page boundary writing wraps to page start
// - Address polling acknowledged only after programming ends
// - Counter holds last address plus one
// - Reads wrap whole array, writes wrap page
// - Current read sends counter byte after acknowledge
// - Sequential read continues while controller acknowledges
// - Three address bits select the page
// - Data fall with clock high starts, rise stops
// - Device pulls data low on ninth clock
// - Data changes only while clock is low
`timescale 1ns/1ns
`default_nettype none
`include "eeacc_params.svh"
module eeacc_top #(
   parameter int unsigned P_TWR_CYC = `EEACC_TWR_CYC
) (
   input  wire logic i_core_clk,
   input  wire logic i_rstn,
   input  wire logic i_link_clk,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_o,
   output logic      o_sda_oe_n,
   output logic      o_busy
);
   import eeacc_pkg::*;

   // ************************************************************
   // Checks on parameters
   // ************************************************************
   if (P_TWR_CYC < 1) begin : g_chk
      $error("Programming time must be at least one cycle");
   end

   // ************************************************************
   // Link side: pin sampling and event detection
   // ************************************************************
   eeacc_link_t l, next_l;   // Sampler state
   logic        nscl;        // Filtered clock after this sample
   logic        nsda;        // Filtered data after this sample

   // Three stages per pin; a level counts once stages two and three agree
   always_comb begin
      next_l       = l;
      next_l.scl_p = {l.scl_p[1:0], i_scl};
      next_l.sda_p = {l.sda_p[1:0], i_sda};
      nscl         = (l.scl_p[1] == l.scl_p[2]) ? l.scl_p[2] : l.scl_f;
      nsda         = (l.sda_p[1] == l.sda_p[2]) ? l.sda_p[2] : l.sda_f;
      next_l.scl_f = nscl;
      next_l.sda_f = nsda;
      next_l.ev_v  = 1'b0;
      // Clock edges win; data moving under a high clock is a condition
      if (!l.scl_f && nscl) begin
         next_l.ev_v    = 1'b1;
         next_l.ev.kind = EV_RISE;
         next_l.ev.sda  = nsda;
      end else if (l.scl_f && !nscl) begin
         next_l.ev_v    = 1'b1;
         next_l.ev.kind = EV_FALL;
      end else if (l.scl_f && nscl && l.sda_f && !nsda) begin
         next_l.ev_v    = 1'b1;
         next_l.ev.kind = EV_START;
      end else if (l.scl_f && nscl && !l.sda_f && nsda) begin
         next_l.ev_v    = 1'b1;
         next_l.ev.kind = EV_STOP;
      end
   end

   // Lines idle high, so the filters start high
   always_ff @(posedge i_link_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         l <= '{scl_p: 3'h7, sda_p: 3'h7, scl_f: 1'b1, sda_f: 1'b1, ev_v: 1'b0, ev: '0};
      end else begin
         l <= next_l;
      end
   end

   // ************************************************************
   // Crossing into the core clock
   // ************************************************************
   logic      ev_v;   // One-cycle event strobe, core domain
   eeacc_ev_t ev;     // Event carried with it

   // Edges come at most every fifteen or so core cycles, so toggling is enough
   eeacc_evsync u_evsync (
      .i_link_clk (i_link_clk),
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_src_v    (l.ev_v),
      .i_src_ev   (l.ev),
      .o_dst_v    (ev_v),
      .o_dst_ev   (ev)
   );

   // ************************************************************
   // Write buffer and array
   // ************************************************************
   eeacc_core_t c, next_c;                                // Engine state
   logic        b_in_ready;                               // Buffer has room
   logic        b_out_v;                                  // Buffer holds a byte
   eeacc_wr_t   b_out;                                    // Oldest byte
   logic        b_pop;                                    // Byte goes to the array
   logic [`EEACC_BYTE_BITS-1:0] mem [0:(1<<`EEACC_ADDR_BITS)-1];  // Array
   logic [`EEACC_BYTE_BITS-1:0] rd_q;                     // Byte at the counter

   // Array takes a byte at most every other cycle; pushes come a whole byte apart, so the buffer never fills
   assign b_pop = b_out_v & ~c.dgap;

   eeacc_buf2 u_buf (
      .i_core_clk  (i_core_clk),
      .i_rstn      (i_rstn),
      .i_in_v      (c.push),
      .i_in        (c.wr),
      .o_in_ready  (b_in_ready),
      .o_out_v     (b_out_v),
      .o_out       (b_out),
      .i_out_ready (~c.dgap)
   );

   // Array port; the read follows the counter all the time
   always_ff @(posedge i_core_clk) begin
      if (b_pop) begin
         mem[b_out.addr] <= b_out.data;
      end
      rd_q <= mem[c.addr];
   end

   // ************************************************************
   // Protocol engine
   // ************************************************************
   always_comb begin
      next_c      = c;
      next_c.push = 1'b0;
      next_c.dgap = b_pop;
      // Programming timer
      if (c.busy) begin
         next_c.tmr = c.tmr - 32'h1;
         if (c.tmr == 32'h1) begin
            next_c.busy = 1'b0;
         end
      end
      if (ev_v) begin
         case (ev.kind)
            // Any start restarts address intake; a partial byte is lost
            EV_START: begin
               next_c.st   = ST_DEV;
               next_c.cnt  = 4'h0;
               next_c.oe_n = 1'b1;
            end
            // Stop ends everything; a finished write begins programming
            EV_STOP: begin
               next_c.st   = ST_IDLE;
               next_c.oe_n = 1'b1;
               if (c.pend && !c.busy) begin
                  next_c.busy = 1'b1;
                  next_c.tmr  = P_TWR_CYC;
                  next_c.pend = 1'b0;
               end
            end
            // Bits are taken on the rising clock
            EV_RISE: begin
               case (c.st)
                  ST_DEV, ST_WADR, ST_WDATA: begin
                     next_c.shreg = {c.shreg[6:0], ev.sda};
                     next_c.cnt   = c.cnt + 4'h1;
                  end
                  ST_RDATA: begin
                     next_c.cnt = c.cnt + 4'h1;
                  end
                  ST_RACK: begin
                     next_c.mack = ~ev.sda;
                  end
                  default: begin
                     next_c.cnt = c.cnt;
                  end
               endcase
            end
            // Output moves on the falling clock
            default: begin
               case (c.st)
                  ST_DEV: begin
                     if (c.cnt == 4'h8) begin
                        // Busy device leaves polls unanswered
                        if (c.shreg[7:4] == `EEACC_PREFIX && !c.busy) begin
                           next_c.st   = ST_DEVACK;
                           next_c.oe_n = 1'b0;
                           next_c.rw   = c.shreg[0];
                           next_c.page = c.shreg[3:1];
                        end else begin
                           next_c.st = ST_IDLE;
                        end
                     end
                  end
                  ST_DEVACK: begin
                     next_c.cnt = 4'h0;
                     if (c.rw) begin
                        // Byte at the counter goes out at once
                        next_c.st   = ST_RDATA;
                        next_c.tx   = rd_q;
                        next_c.oe_n = rd_q[7];
                     end else begin
                        next_c.st   = ST_WADR;
                        next_c.oe_n = 1'b1;
                     end
                  end
                  ST_WADR: begin
                     if (c.cnt == 4'h8) begin
                        next_c.addr = {c.page, c.shreg};
                        next_c.st   = ST_WADRACK;
                        next_c.oe_n = 1'b0;
                     end
                  end
                  ST_WDATA: begin
                     if (c.cnt == 4'h8) begin
                        // No room means no acknowledge and the byte is lost
                        if (b_in_ready) begin
                           next_c.push    = 1'b1;
                           next_c.wr      = '{addr: c.addr, data: c.shreg};
                           next_c.addr[`EEACC_WRAP_BITS-1:0] =
                              c.addr[`EEACC_WRAP_BITS-1:0] + `EEACC_WRAP_BITS'(1);
                           next_c.pend    = 1'b1;
                           next_c.st      = ST_WDATACK;
                           next_c.oe_n    = 1'b0;
                        end else begin
                           next_c.st = ST_IDLE;
                        end
                     end
                  end
                  ST_WADRACK, ST_WDATACK: begin
                     next_c.st   = ST_WDATA;
                     next_c.cnt  = 4'h0;
                     next_c.oe_n = 1'b1;
                  end
                  ST_RDATA: begin
                     if (c.cnt == 4'h8) begin
                        // Let go for the controller's answer; count wraps the array
                        next_c.oe_n = 1'b1;
                        next_c.st   = ST_RACK;
                        next_c.addr = c.addr + `EEACC_ADDR_BITS'(1);
                     end else begin
                        next_c.tx   = {c.tx[6:0], 1'b0};
                        next_c.oe_n = c.tx[6];
                     end
                  end
                  ST_RACK: begin
                     next_c.cnt = 4'h0;
                     if (c.mack) begin
                        next_c.st   = ST_RDATA;
                        next_c.tx   = rd_q;
                        next_c.oe_n = rd_q[7];
                     end else begin
                        next_c.st   = ST_IDLE;
                        next_c.oe_n = 1'b1;
                     end
                  end
                  default: begin
                     next_c.st = c.st;
                  end
               endcase
            end
         endcase
      end
   end

   // Counter clears only at reset, standing for power-up
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         c <= '{st: ST_IDLE, oe_n: 1'b1, default: '0};
      end else begin
         c <= next_c;
      end
   end

   // Open drain: only ever pull low
   assign o_sda_o    = 1'b0;
   assign o_sda_oe_n = c.oe_n;
   assign o_busy     = c.busy;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   logic fall_ev;   // Falling clock event
   logic dev_done;  // Eighth address bit in
   assign fall_ev  = ev_v && ev.kind == EV_FALL;
   assign dev_done = fall_ev && c.st == ST_DEV && c.cnt == 4'h8;

   sequence s_read_ack;
      fall_ev && c.st == ST_DEVACK && c.rw;
   endsequence
   sequence s_first_bit;
      c.st == ST_RDATA && c.oe_n == c.tx[7] && c.cnt == 4'h0;
   endsequence

   a_rw_select: assert property (
      dev_done && c.shreg[7:4] == `EEACC_PREFIX && !c.busy |=> c.st == ST_DEVACK && c.rw == $past(c.shreg[0]))
      else $error("Direction bit not taken");
   a_match_ack: assert property (
      dev_done && c.shreg[7:4] != `EEACC_PREFIX |=> c.st == ST_IDLE && c.oe_n)
      else $error("Foreign address answered");
   a_ack_low: assert property (
      c.st == ST_DEVACK || c.st == ST_WADRACK || c.st == ST_WDATACK |-> !o_sda_oe_n)
      else $error("Ninth clock not pulled low");
   a_busy_silent: assert property (
      dev_done && c.busy |=> c.st == ST_IDLE ##1 o_sda_oe_n[*3])
      else $error("Answered while programming");
   a_prog_start: assert property (
      ev_v && ev.kind == EV_STOP && c.pend && !c.busy |=> c.busy && c.tmr == P_TWR_CYC)
      else $error("Programming not started");
   a_page_wrap: assert property (
      fall_ev && c.st == ST_WDATA && c.cnt == 4'h8 && b_in_ready
      |=> c.addr[10:3] == $past(c.addr[10:3]) && c.addr[2:0] == $past(c.addr[2:0]) + 3'h1)
      else $error("Write address step wrong");
   a_read_step: assert property (
      fall_ev && c.st == ST_RDATA && c.cnt == 4'h8 |=> c.addr == $past(c.addr) + 11'h1 && c.st == ST_RACK)
      else $error("Read address step wrong");
   a_word_load: assert property (
      fall_ev && c.st == ST_WADR && c.cnt == 4'h8 |=> c.addr == {$past(c.page), $past(c.shreg)})
      else $error("Word address not loaded");
   a_read_first: assert property (
      s_read_ack |=> s_first_bit)
      else $error("First read bit not driven");
   a_start_abort: assert property (
      ev_v && ev.kind == EV_START |=> c.st == ST_DEV && c.cnt == 4'h0 && o_sda_oe_n)
      else $error("Start did not restart");
endmodule
`default_nettype wire

// file: tb/eeacc_ctl.sv
// Bus controller model that drives the two-wire link
`timescale 1ns/1ns
`default_nettype none
module eeacc_ctl (
   output logic      o_scl, // Serial clock, idles high
   output logic      o_sda, // Open-drain data drive, 1 releases
   input  wire logic i_sda  // Resolved data wire
);
   // ****************
   // Bus cycles
   // ****************
   // Idle bus: both lines released
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // One bit slot; data moves only with the clock low, 60 ns hold after the fall
   task automatic bit_slot(input logic b, output logic s);
      #60 o_sda = b;
      #60 o_scl = 1'b1;
      #60 s = i_sda;
      #60 o_scl = 1'b0;
   endtask
   // Start, also used as a repeated start
   task automatic start();
      #60 o_sda = 1'b1;
      #60 o_scl = 1'b1;
      #120 o_sda = 1'b0;
      #120 o_scl = 1'b0;
   endtask
   // Stop leaves the bus idle and the clock still
   task automatic stop();
      #60 o_sda = 1'b0;
      #60 o_scl = 1'b1;
      #120 o_sda = 1'b1;
      #120;
   endtask
   // Byte out MSB first; ack is the device pulling low on the ninth clock
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask
   // Byte in; more keeps a sequential read going, else no ack
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, d[i]);
      end
      bit_slot(~more, s);
   endtask
endmodule
`default_nettype wire

// file: tb/eeacc_top_bench.sv
// Bench of the two-wire access engine against a controller model
`timescale 1ns/1ns
`default_nettype none
module eeacc_top_bench;
   // ****************
   // Signals
   // ****************
   localparam int unsigned TWR = 2000; // Short programming time
   typedef struct {logic [10:0] a; logic [7:0] d;} eeacc_row_t;
   logic       core_clk = 1'b0; // 250 MHz
   logic       link_clk = 1'b0; // 12 ns sampler clock
   logic       rstn     = 1'b0; // Active-low reset
   logic       scl;             // Controller clock
   logic       ctl_sda;         // Controller data drive
   logic       sda_oe_n;        // Device drives the wire when 0
   logic       sda_o;           // Level the device drives
   logic       busy;            // Programming in progress
   wire        sda = ctl_sda & (sda_oe_n | sda_o); // Pulled-up wire
   int         n_errors = 0;
   int         tests_run = 0;
   int         cyc = 0;
   int         e;
   logic       k;
   logic [7:0] got [0:9];
   // Ordinary cases: address and byte, read back after writing
   eeacc_row_t rows [4] = '{'{11'h123, 8'h5a}, '{11'h7ff, 8'ha5}, '{11'h000, 8'h3c}, '{11'h001, 8'hc3}};
   always #2 core_clk = ~core_clk;
   // Offset start keeps the two clocks apart in phase
   initial begin
      #1;
      forever #6 link_clk = ~link_clk;
   end
   eeacc_top #(.P_TWR_CYC(TWR)) i_dut (
      .i_core_clk (core_clk),
      .i_rstn     (rstn),
      .i_link_clk (link_clk),
      .i_scl      (scl),
      .i_sda      (sda),
      .o_sda_o    (sda_o),
      .o_sda_oe_n (sda_oe_n),
      .o_busy     (busy)
   );
   eeacc_ctl i_ctl (
      .o_scl (scl),
      .o_sda (ctl_sda),
      .i_sda (sda)
   );
   // ****************
   // Helpers
   // ****************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Device byte: fixed prefix, page bits, direction
   function automatic logic [7:0] dev(input logic [10:0] a, input logic rd);
      return {4'ha, a[10:8], rd};
   endfunction
   // Write n bytes from d0 upward, then poll through programming
   task automatic wr(input logic [10:0] a, input int n, input logic [7:0] d0);
      i_ctl.start();
      i_ctl.wbyte(dev(a, 1'b0), k);
      check(k, 1'b1);
      i_ctl.wbyte(a[7:0], k);
      check(k, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_ctl.wbyte(d0 + i[7:0], k);
         check(k, 1'b1);
      end
      i_ctl.stop();
      #100 check(busy, 1'b1);
      i_ctl.start();
      i_ctl.wbyte(dev(a, 1'b0), k);
      i_ctl.stop();
      check(k, 1'b0);
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
         @(negedge core_clk);
      end
      i_ctl.start();
      i_ctl.wbyte(dev(a, 1'b0), k);
      i_ctl.stop();
      check(k, 1'b1);
   endtask
   // Random or current read of n bytes into got
   task automatic rd(input logic rnd, input logic [10:0] a, input int n);
      if (rnd) begin
         i_ctl.start();
         i_ctl.wbyte(dev(a, 1'b0), k);
         i_ctl.wbyte(a[7:0], k);
      end
      i_ctl.start();
      i_ctl.wbyte(dev(a, 1'b1), k);
      check(k, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_ctl.rbyte(i < n - 1, got[i]);
      end
      i_ctl.stop();
   endtask
   // Hang guard, well above the expected run
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_errors++;
         conclude();
      end
   end
   // ****************
   // Sequence
   // ****************
   initial begin
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      check(busy, 1'b0);
      #200;
      foreach (rows[i]) begin
         wr(rows[i].a, 1, rows[i].d);
         rd(1'b1, rows[i].a, 1);
         check(got[0], rows[i].d);
      end
      // Wrong prefix gets no answer
      i_ctl.start();
      i_ctl.wbyte(8'h50, k);
      i_ctl.stop();
      check(k, 1'b0);
      // Read across the top of the array, then from the counter
      rd(1'b1, 11'h7ff, 2);
      check(got[0], 8'ha5);
      check(got[1], 8'h3c);
      rd(1'b0, 11'h000, 1);
      check(got[0], 8'hc3);
      // Stop after four data bits: nothing may be programmed
      i_ctl.start();
      i_ctl.wbyte(dev(11'h123, 1'b0), k);
      i_ctl.wbyte(8'h23, k);
      for (int i = 0; i < 4; i++) begin
         i_ctl.bit_slot(1'b0, k);
      end
      i_ctl.stop();
      #100 check(busy, 1'b0);
      rd(1'b1, 11'h123, 1);
      check(got[0], 8'h5a);
      // Ten bytes from offset 5 wrap inside one eight-byte span
      wr(11'h2fd, 10, 8'h80);
      rd(1'b1, 11'h2f8, 8);
      for (int j = 0; j < 8; j++) begin
         e = (j + 3) % 8;
         if (e < 2) begin
            e += 8;
         end
         check(got[j], 8'h80 + e[7:0]);
      end
      // Reset in mid-programming: busy drops, the wire is let go, the counter restarts at zero
      i_ctl.start();
      i_ctl.wbyte(dev(11'h400, 1'b0), k);
      i_ctl.wbyte(8'h00, k);
      i_ctl.wbyte(8'h77, k);
      i_ctl.stop();
      #100 check(busy, 1'b1);
      @(negedge core_clk);
      rstn = 1'b0;
      // Long enough to span two link clock edges as well
      repeat (6) @(negedge core_clk);
      check(busy, 1'b0);
      check(sda_oe_n, 1'b1);
      rstn = 1'b1;
      #200;
      rd(1'b0, 11'h000, 1);
      check(got[0], 8'h3c);
      conclude();
   end
endmodule
`default_nettype wire
